// *** lsar_des_model.sv ***
`timescale 1ns/1ns
module lsar_des_model
   import lsar_pkg::*;
(
   // clock
   input  wire logic mclk,
   // link events toward the register slice
   output lsar_evt_s evt
);
   // quiet link until the bench asks for traffic
   initial evt = '0;

   // burst of back-to-back crc errors; act marks self-test traffic
   task automatic crc(input int n, input logic act);
      repeat (n) begin
         @(posedge mclk);
         evt.bc_crc_err      <= 1'b1;
         evt.selftest_active <= act;
      end
      @(posedge mclk);
      evt <= '0;
   endtask : crc

   // one-cycle pulse: bit 0 loss of link, bit 1 self-test restart
   task automatic pulse(input int which);
      @(posedge mclk);
      evt[which] <= 1'b1;
      @(posedge mclk);
      evt <= '0;
   endtask : pulse
endmodule : lsar_des_model

// *** lsar_pkg.sv ***
package lsar_pkg;
   // register offsets (byte addresses on the 8-bit register port)
   localparam logic [7:0] LSAR_OFS_ALIAS    = 8'h08;
   localparam logic [7:0] LSAR_OFS_CNT_LO   = 8'h0a;
   localparam logic [7:0] LSAR_OFS_CNT_HI   = 8'h0b;
   localparam logic [7:0] LSAR_OFS_STATUS   = 8'h0c;
   localparam logic [7:0] LSAR_OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] LSAR_OFS_IRQ_MASK = 8'h11;

   // reset values, and the saturation limit of the error count
   localparam logic [7:0]  LSAR_ALIAS_RST = 8'h00;
   localparam logic [15:0] LSAR_CNT_RST   = 16'h0000;
   localparam logic [15:0] LSAR_CNT_MAX   = 16'hffff;
   localparam logic [7:0]  LSAR_RD_RST    = 8'h00;
   localparam logic [2:0]  LSAR_IRQ_RST   = 3'h0;

   // alias field position: bits 7:1, bit 0 reserved
   localparam int LSAR_ALIAS_LSB = 1;

   // general status bit positions
   localparam int LSAR_ST_LINK_LOST = 4;
   localparam int LSAR_ST_SELFTEST  = 3;
   localparam int LSAR_ST_CLK_VALID = 2;
   localparam int LSAR_ST_DES_ERR   = 1;
   localparam int LSAR_ST_LINK_DET  = 0;

   // interrupt status / mask bit positions
   localparam int LSAR_IRQ_LOST     = 0;
   localparam int LSAR_IRQ_SELFTEST = 1;
   localparam int LSAR_IRQ_DES      = 2;

   // a control transaction on its way across the back channel
   typedef struct packed {
      logic       valid;
      logic [6:0] addr;
   } lsar_fwd_s;

   // link events from the back-channel logic, one-cycle pulses except active
   typedef struct packed {
      logic bc_crc_err;
      logic selftest_active;
      logic selftest_start;
      logic link_loss;
   } lsar_evt_s;
endpackage : lsar_pkg

// *** lsar_regs.sv ***
// Function
// - a 7-bit alias in bits 7:1 re-addresses hits to remote target 0.
// - while the alias field is zero no request goes to remote target 0.
// - the remote target 0 address is the 7-bit address sent onward.
// - CRC errors are counted, low byte at 0x0A, cleared by error reset.
// - the count's high byte reads at 0x0B and clears with the low byte.
// - link-lost at bit 4 sets on loss of link and holds until error reset.
// - the self-test CRC flag at bit 3 sets on a CRC error in self-test.
// - link loss, self-test restart or error reset clear bit 3.
// - bit 2 shows live whether a valid input clock is detected.
// - bit 1 flags a CRC error seen in normal deserializer traffic.
// - the deserializer error flag clears on loss of link or error reset.
// - bit 0 shows live whether a cable link is detected.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module lsar_regs
   import lsar_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst_b,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // error-reset control bit, held elsewhere
   input  wire logic       error_reset,
   // back-channel events
   input  wire lsar_evt_s  evt,
   // live pins
   input  wire logic       input_clock_valid,
   input  wire logic       cable_link_detect,
   // forwarding path
   input  wire logic [6:0] remote_target0_address,
   input  wire lsar_fwd_s  fwd_in,
   output lsar_fwd_s       fwd_out,
   output logic            fwd_refuse,
   // interrupt
   output logic            irq
);

   // sticky flag: a set in the same cycle as a clear wins
   function automatic logic sticky(input logic cur, input logic set,
                                   input logic clr);
      sticky = set | (cur & ~clr);
   endfunction : sticky

   logic [1:0]  clk_sync_r, clk_sync_nxt;
   logic [1:0]  lnk_sync_r, lnk_sync_nxt;
   logic [7:0]  alias_r, alias_nxt;
   logic [15:0] cnt_r, cnt_nxt;
   logic        lost_r, lost_nxt;
   logic        self_r, self_nxt;
   logic        des_r, des_nxt;
   logic [2:0]  irq_stat_r, irq_stat_nxt;
   logic [2:0]  irq_mask_r, irq_mask_nxt;
   logic        irq_nxt;
   lsar_fwd_s   fwd_nxt;
   logic        refuse_nxt;
   logic [7:0]  rdata_nxt;
   logic [7:0]  status_w;
   logic [6:0]  alias_w;
   logic        self_set, des_set;

   // pin synchronisers: the second stage is the only reader of the first
   // live status bits lag their pins by two clocks; glitches may be missed
   always_comb begin
      clk_sync_nxt = {clk_sync_r[0], input_clock_valid};
      lnk_sync_nxt = {lnk_sync_r[0], cable_link_detect};
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         clk_sync_r <= 2'h0;
         lnk_sync_r <= 2'h0;
      end else begin
         clk_sync_r <= clk_sync_nxt;
         lnk_sync_r <= lnk_sync_nxt;
      end
   end

   // error count and link flags
   always_comb begin
      self_set = evt.bc_crc_err & evt.selftest_active;
      des_set  = evt.bc_crc_err & ~evt.selftest_active;
      if (evt.bc_crc_err) begin
         if (error_reset)
            cnt_nxt = LSAR_CNT_RST + 16'h0001;
         else if (cnt_r == LSAR_CNT_MAX)
            cnt_nxt = cnt_r;
         else
            cnt_nxt = cnt_r + 16'h0001;
      end else if (error_reset) begin
         cnt_nxt = LSAR_CNT_RST;
      end else begin
         cnt_nxt = cnt_r;
      end
      lost_nxt = sticky(lost_r, evt.link_loss, error_reset);
      self_nxt = sticky(self_r, self_set,
                        evt.link_loss | evt.selftest_start | error_reset);
      des_nxt  = sticky(des_r, des_set, evt.link_loss | error_reset);
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cnt_r  <= LSAR_CNT_RST;
         lost_r <= 1'b0;
         self_r <= 1'b0;
         des_r  <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         lost_r <= lost_nxt;
         self_r <= self_nxt;
         des_r  <= des_nxt;
      end
   end

   // software registers: alias, interrupt status (write one to clear), mask
   always_comb begin
      alias_nxt    = alias_r;
      irq_mask_nxt = irq_mask_r;
      irq_stat_nxt = irq_stat_r;
      if (reg_wr && reg_addr == LSAR_OFS_ALIAS)
         alias_nxt = {reg_wdata[7:LSAR_ALIAS_LSB], 1'b0}; // bit 0 reserved
      if (reg_wr && reg_addr == LSAR_OFS_IRQ_MASK)
         irq_mask_nxt = reg_wdata[2:0];
      if (reg_wr && reg_addr == LSAR_OFS_IRQ_STAT)
         irq_stat_nxt = irq_stat_r & ~reg_wdata[2:0];
      // events set after the clear so a same-cycle event is kept
      irq_stat_nxt[LSAR_IRQ_LOST]     = irq_stat_nxt[LSAR_IRQ_LOST]
                                        | evt.link_loss;
      irq_stat_nxt[LSAR_IRQ_SELFTEST] = irq_stat_nxt[LSAR_IRQ_SELFTEST]
                                        | self_set;
      irq_stat_nxt[LSAR_IRQ_DES]      = irq_stat_nxt[LSAR_IRQ_DES]
                                        | des_set;
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         alias_r    <= LSAR_ALIAS_RST;
         irq_stat_r <= LSAR_IRQ_RST;
         irq_mask_r <= LSAR_IRQ_RST;
         irq        <= 1'b0;
      end else begin
         alias_r    <= alias_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         irq        <= irq_nxt;
      end
   end

   // forwarding toward remote target 0, one cycle of latency
   always_comb begin
      alias_w    = alias_r[7:LSAR_ALIAS_LSB];
      fwd_nxt    = '0;
      refuse_nxt = 1'b0;
      if (fwd_in.valid) begin
         if (alias_w == 7'h00) begin
            refuse_nxt = 1'b1;
         end else if (fwd_in.addr == alias_w) begin
            fwd_nxt.valid = 1'b1;
            fwd_nxt.addr  = remote_target0_address;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         fwd_out    <= '0;
         fwd_refuse <= 1'b0;
      end else begin
         fwd_out    <= fwd_nxt;
         fwd_refuse <= refuse_nxt;
      end
   end

   // status byte and read mux; data stands only in the cycle after the strobe
   always_comb begin
      status_w = 8'h00; // reserved bits 7:5 read zero
      status_w[LSAR_ST_LINK_LOST] = lost_r;
      status_w[LSAR_ST_SELFTEST]  = self_r;
      status_w[LSAR_ST_CLK_VALID] = clk_sync_r[1];
      status_w[LSAR_ST_DES_ERR]   = des_r;
      status_w[LSAR_ST_LINK_DET]  = lnk_sync_r[1];
      rdata_nxt = LSAR_RD_RST;
      if (reg_rd) begin
         case (reg_addr)
            LSAR_OFS_ALIAS:    rdata_nxt = alias_r;
            LSAR_OFS_CNT_LO:   rdata_nxt = cnt_r[7:0];
            LSAR_OFS_CNT_HI:   rdata_nxt = cnt_r[15:8];
            LSAR_OFS_STATUS:   rdata_nxt = status_w;
            LSAR_OFS_IRQ_STAT: rdata_nxt = {5'h00, irq_stat_r};
            LSAR_OFS_IRQ_MASK: rdata_nxt = {5'h00, irq_mask_r};
            default:           rdata_nxt = LSAR_RD_RST; // unmapped
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b)
         reg_rdata <= LSAR_RD_RST;
      else
         reg_rdata <= rdata_nxt;
   end

   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   a_alias_remap_hit: assert property (
      fwd_in.valid && alias_r[7:1] != 7'h00 && fwd_in.addr == alias_r[7:1]
      |=> fwd_out.valid && !fwd_refuse)
      else $error("alias hit not forwarded");

   a_zero_refuse: assert property (
      fwd_in.valid && alias_r[7:1] == 7'h00 |=> fwd_refuse && !fwd_out.valid)
      else $error("zero alias not refused");

   a_remap_addr: assert property (
      fwd_out.valid |-> fwd_out.addr == $past(remote_target0_address))
      else $error("forwarded address wrong");

   a_cnt_step: assert property (
      evt.bc_crc_err && !error_reset && cnt_r != 16'hffff
      |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("error count did not step");

   a_cnt_clear: assert property (
      error_reset && !evt.bc_crc_err
      ##1 !evt.bc_crc_err && !reg_rd
      |=> cnt_r == 16'h0000 && reg_rdata == 8'h00)
      else $error("error count not cleared");

   a_cnt_saturate: assert property (
      cnt_r == 16'hffff && !error_reset |=> cnt_r == 16'hffff)
      else $error("error count wrapped");

   a_lost_sticky: assert property (
      evt.link_loss ##1 !error_reset [*3] |-> lost_r)
      else $error("link lost flag dropped");

   a_self_set: assert property (
      evt.bc_crc_err && evt.selftest_active |=> self_r && irq_stat_r[1])
      else $error("self-test error not flagged");

   a_self_clear: assert property (
      (evt.link_loss || evt.selftest_start || error_reset) &&
      !(evt.bc_crc_err && evt.selftest_active) |=> !self_r)
      else $error("self-test error not cleared");

   a_clk_live: assert property (
      $past(rst_b, 2) |-> status_w[2] == $past(input_clock_valid, 2))
      else $error("clock detect not live");

   a_des_set: assert property (
      evt.bc_crc_err && !evt.selftest_active |=> des_r ##1 (des_r || $past(
      evt.link_loss || error_reset)))
      else $error("deserializer error not flagged");

   a_des_clear: assert property (
      (evt.link_loss || error_reset) &&
      !(evt.bc_crc_err && !evt.selftest_active) |=> !des_r)
      else $error("deserializer error not cleared");

   a_link_live: assert property (
      $past(rst_b, 2) |-> status_w[0] == $past(cable_link_detect, 2))
      else $error("link detect not live");

   a_alias_write: assert property (
      reg_wr && reg_addr == LSAR_OFS_ALIAS
      |=> alias_r[7:1] == $past(reg_wdata[7:1]) && !alias_r[0])
      else $error("alias write not stored");

   a_rdata_idle: assert property ( // read port idle
      !reg_rd |=> reg_rdata == LSAR_RD_RST)
      else $error("read data not idle");

   a_irq_level: assert property ( // interrupt output
      irq == |(irq_stat_r & irq_mask_r))
      else $error("interrupt level wrong");

   c_remap: cover property (fwd_out.valid);
   c_refuse: cover property (fwd_refuse);
   c_saturate: cover property (cnt_r == 16'hffff ##1 evt.bc_crc_err);
   c_irq: cover property (irq ##[1:20] !irq);
   c_link_lost: cover property (evt.link_loss ##1 lost_r);

endmodule : lsar_regs

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench
   import lsar_pkg::*;
;
   // stimulus and observed outputs
   logic       mclk, rst_b, reg_wr, reg_rd, error_reset;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       clk_ok, link_ok, fwd_refuse, irq;
   logic [6:0] tgt_addr;
   lsar_evt_s  evt;
   lsar_fwd_s  fwd_in, fwd_out;
   int         err_count = 0;
   int         tests_run = 0;

   lsar_regs u_lsar_regs (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .error_reset(error_reset), .evt(evt),
      .input_clock_valid(clk_ok), .cable_link_detect(link_ok),
      .remote_target0_address(tgt_addr), .fwd_in(fwd_in), .fwd_out(fwd_out),
      .fwd_refuse(fwd_refuse), .irq(irq));
   lsar_des_model u_lsar_des_model (.mclk(mclk), .evt(evt));

   // 250 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic chk(input logic [7:0] got, exp, input string m);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, exp);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp, "read");
   endtask : rd

   task automatic fw(input logic [6:0] a, input logic v, r);
      @(posedge mclk);
      fwd_in <= {1'b1, a};
      @(posedge mclk);
      fwd_in <= '0;
      #1 chk(8'(fwd_out.valid), 8'(v), "fwd valid");
      chk(8'(fwd_refuse), 8'(r), "fwd refuse");
      if (v) chk(8'(fwd_out.addr), 8'(tgt_addr), "fwd addr");
   endtask : fw

   task automatic err_rst();
      @(posedge mclk);
      error_reset <= 1'b1;
      @(posedge mclk);
      error_reset <= 1'b0;
   endtask : err_rst

   task automatic t_reset();
      rd(8'h08, 8'h00);
      rd(8'h0a, 8'h00);
      rd(8'h0b, 8'h00);
      rd(8'h0c, 8'h04);
      rd(8'h3f, 8'h00);
   endtask : t_reset

   task automatic t_alias();
      fw(7'h00, 1'b0, 1'b1);
      wr(8'h08, 8'h55);
      rd(8'h08, 8'h54);
      fw(7'h2a, 1'b1, 1'b0);
      fw(7'h2b, 1'b0, 1'b0);
      @(posedge mclk);
      tgt_addr <= 7'h11;
      fw(7'h2a, 1'b1, 1'b0);
      wr(8'h08, 8'h00);
      fw(7'h2a, 1'b0, 1'b1);
   endtask : t_alias

   task automatic t_crc();
      wr(8'h11, 8'h04);
      u_lsar_des_model.crc(3, 1'b0);
      rd(8'h0a, 8'h03);
      rd(8'h0c, 8'h06);
      chk(8'(irq), 8'h01, "irq on");
      wr(8'h0a, 8'hff);
      rd(8'h0a, 8'h03);
      wr(8'h10, 8'h04);
      rd(8'h10, 8'h00);
      chk(8'(irq), 8'h00, "irq cleared");
      err_rst();
      rd(8'h0a, 8'h00);
      rd(8'h0c, 8'h04);
   endtask : t_crc

   task automatic t_selftest();
      wr(8'h11, 8'h00);
      u_lsar_des_model.crc(2, 1'b1);
      rd(8'h0c, 8'h0c);
      u_lsar_des_model.pulse(1);
      rd(8'h0c, 8'h04);
      u_lsar_des_model.crc(1, 1'b1);
      u_lsar_des_model.crc(1, 1'b0);
      rd(8'h0c, 8'h0e);
      rd(8'h10, 8'h06);
      chk(8'(irq), 8'h00, "irq masked");
      u_lsar_des_model.pulse(0);
      rd(8'h0c, 8'h14);
      wr(8'h11, 8'h01);
      rd(8'h0c, 8'h14);
      chk(8'(irq), 8'h01, "irq lost");
      wr(8'h10, 8'h07);
      wr(8'h11, 8'h00);
      err_rst();
      rd(8'h0c, 8'h04);
      chk(8'(irq), 8'h00, "irq off");
   endtask : t_selftest

   task automatic t_pins();
      @(posedge mclk);
      clk_ok  <= 1'b0;
      link_ok <= 1'b1;
      repeat (4) @(posedge mclk);
      rd(8'h0c, 8'h01);
      @(posedge mclk);
      clk_ok  <= 1'b1;
      link_ok <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(8'h0c, 8'h04);
   endtask : t_pins

   task automatic t_sat();
      u_lsar_des_model.crc(256, 1'b0);
      rd(8'h0a, 8'h00);
      rd(8'h0b, 8'h01);
      u_lsar_des_model.crc(65300, 1'b0);
      rd(8'h0a, 8'hff);
      rd(8'h0b, 8'hff);
   endtask : t_sat

   task automatic end_sim();
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   // main sequence
   initial begin
      {rst_b, reg_wr, reg_rd, error_reset, link_ok} = '0;
      {reg_addr, reg_wdata, fwd_in} = '0;
      clk_ok = 1'b1;
      tgt_addr = 7'h3c;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      t_reset();
      t_alias();
      t_crc();
      t_selftest();
      t_pins();
      t_sat();
      end_sim();
   end

   // watchdog well beyond the saturation burst
   initial begin
      repeat (80000) @(posedge mclk);
      err_count++;
      end_sim();
   end
endmodule : testbench
